// ===== design/intc_prio_pkg.sv
package intc_prio_pkg;
   localparam int NUM_SRC = 14;
   localparam int PRIO_W = 3;
   localparam int LEVEL_W = 4;
   localparam int VEC_W = 7;
   localparam int REG_W = 16;
   localparam int ADDR_W = 8;
   localparam int NUM_EVT = 2;
   localparam int NUM_PRIO_REGS = 6;

   // byte addresses of the register map
   localparam logic [7:0] OFF_UART_RX_SPI_TIMER_PRIORITY = 8'h00;
   localparam logic [7:0] OFF_ADC_UART_TX_PRIORITY = 8'h04;
   localparam logic [7:0] OFF_PIN_CHANGE_I2C_PRIORITY = 8'h08;
   localparam logic [7:0] OFF_CAPTURE_EXTPIN_PRIORITY = 8'h0c;
   localparam logic [7:0] OFF_EXTPIN_TWO_PRIORITY = 8'h10;
   localparam logic [7:0] OFF_UART_ERROR_PRIORITY = 8'h14;
   localparam logic [7:0] OFF_PENDING_VECTOR_STATUS = 8'h18;
   localparam logic [7:0] OFF_EVENT_STATUS = 8'h1c;
   localparam logic [7:0] OFF_EVENT_MASK = 8'h20;

   localparam logic [7:0] PRIO_REG_OFF [NUM_PRIO_REGS] = '{
      OFF_UART_RX_SPI_TIMER_PRIORITY, OFF_ADC_UART_TX_PRIORITY, OFF_PIN_CHANGE_I2C_PRIORITY,
      OFF_CAPTURE_EXTPIN_PRIORITY, OFF_EXTPIN_TWO_PRIORITY, OFF_UART_ERROR_PRIORITY};

   // source indices, ordered by rising vector code
   localparam int SRC_TIMER_THREE = 0;
   localparam int SRC_SPI_ERROR = 1;
   localparam int SRC_SPI_EVENT = 2;
   localparam int SRC_UART_RX = 3;
   localparam int SRC_UART_TX = 4;
   localparam int SRC_ADC_DONE = 5;
   localparam int SRC_I2C_SLAVE = 6;
   localparam int SRC_I2C_MASTER = 7;
   localparam int SRC_PIN_CHANGE = 8;
   localparam int SRC_EXT_PIN_ONE = 9;
   localparam int SRC_CAPTURE_SEVEN = 10;
   localparam int SRC_CAPTURE_EIGHT = 11;
   localparam int SRC_EXT_PIN_TWO = 12;
   localparam int SRC_UART_ERROR = 13;

   // which priority register and which low bit holds each source's field
   localparam int SRC_REG [NUM_SRC] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 3, 3, 3, 4, 5};
   localparam int SRC_LSB [NUM_SRC] = '{0, 4, 8, 12, 0, 4, 0, 4, 12, 0, 8, 12, 4, 4};
   // pending vector code per source (code 0 is vector 8)
   localparam logic [6:0] SRC_VEC [NUM_SRC] = '{
      7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h10, 7'h11, 7'h13, 7'h14, 7'h16, 7'h17, 7'h1d, 7'h41};

   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] PRIO_DISABLED = 3'h0;
   localparam int STAT_LEVEL_LSB = 8;
   localparam int STAT_VEC_LSB = 0;
   localparam int EVT_NEW_PENDING = 0;
   localparam int EVT_CPU_ACK = 1;
   localparam logic [1:0] EVT_MASK_RESET = 2'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== design/axil_reg_slave.sv
`timescale 1ns/10ps
module axil_reg_slave #(
   parameter int ADDR_W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wrFire,
   output logic [ADDR_W-1:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrHit,
   output logic [ADDR_W-1:0] rdAddr,
   input wire logic [31:0] rdData,
   input wire logic rdHit
);
   typedef struct packed {
      logic awHeld;
      logic wHeld;
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } state_s;

   state_s st_q;
   state_s st_d;

   // no new address or data while a response waits, so one write is in flight
   assign awready = !st_q.awHeld && !st_q.bValid;
   assign wready = !st_q.wHeld && !st_q.bValid;
   assign arready = !st_q.rValid;
   assign wrFire = st_q.awHeld && st_q.wHeld && !st_q.bValid;
   assign wrAddr = st_q.addr;
   assign wrData = st_q.data;
   assign wrStrb = st_q.strb;
   assign rdAddr = araddr;
   assign bvalid = st_q.bValid;
   assign bresp = st_q.bResp;
   assign rvalid = st_q.rValid;
   assign rdata = st_q.rData;
   assign rresp = st_q.rResp;

   always_comb begin
      st_d = st_q;
      if (awvalid && awready) begin
         st_d.awHeld = 1'b1;
         st_d.addr = awaddr;
      end
      if (wvalid && wready) begin
         st_d.wHeld = 1'b1;
         st_d.data = wdata;
         st_d.strb = wstrb;
      end
      if (wrFire) begin
         st_d.awHeld = 1'b0;
         st_d.wHeld = 1'b0;
         st_d.bValid = 1'b1;
         st_d.bResp = wrHit ? intc_prio_pkg::RESP_OKAY : intc_prio_pkg::RESP_SLVERR;
      end
      if (st_q.bValid && bready) begin
         st_d.bValid = 1'b0;
      end
      if (arvalid && arready) begin
         st_d.rValid = 1'b1;
         st_d.rData = rdHit ? rdData : 32'h0;
         st_d.rResp = rdHit ? intc_prio_pkg::RESP_OKAY : intc_prio_pkg::RESP_SLVERR;
      end else if (st_q.rValid && rready) begin
         st_d.rValid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// ===== design/prio_arbiter.sv
`timescale 1ns/10ps
module prio_arbiter #(
   parameter int NUM_SRC = 14
) (
   input wire logic [NUM_SRC-1:0] srcReq,
   input wire logic [NUM_SRC-1:0][2:0] srcPrio,
   input wire logic [3:0] cpuLevel,
   output logic found,
   output logic [2:0] winPrio,
   output logic [6:0] winVec
);
   typedef struct packed {
      logic found;
      logic [2:0] prio;
      logic [6:0] vec;
   } win_s;

   win_s win;

   assign found = win.found;
   assign winPrio = win.prio;
   assign winVec = win.vec;

   // sources are scanned by rising vector code; only a strictly higher level
   // replaces the holder, so a tie keeps the lower vector
   always_comb begin
      win = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (srcReq[i] && srcPrio[i] != intc_prio_pkg::PRIO_DISABLED &&
             {1'b0, srcPrio[i]} > cpuLevel && (!win.found || srcPrio[i] > win.prio)) begin
            win.found = 1'b1;
            win.prio = srcPrio[i];
            win.vec = intc_prio_pkg::SRC_VEC[i];
         end
      end
   end
endmodule

// ===== design/interrupt_priority_and_status.sv
// What this block does
// - each source has a 3-bit read/write priority, 7 highest down to 1
// - priority code zero disables the source; it is never presented as pending
// - unimplemented bits of priority and status registers read zero, writes ignored
// - status bits 11:8 give the new cpu priority level, 0 to 7
// - status bits 6:0 give pending vector code; code 0 is vector 8
// - second register: uart rx 14:12, spi event 10:8, spi error 6:4, timer three 2:0
// - third register: adc done 6:4, uart tx 2:0, bits 15:7 unused
// - fourth register: pin change 14:12, i2c master 6:4, i2c slave 2:0
// - fifth register: capture eight 14:12, capture seven 10:8, ext pin one 2:0
// - seventh register: only ext pin two at 6:4, rest reads zero
// - sixteenth register: only uart error at 6:4, rest reads zero
// - after reset every implemented priority field holds level 4
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module interrupt_priority_and_status #(
   parameter int NUM_SRC = intc_prio_pkg::NUM_SRC,
   parameter int ADDR_W = intc_prio_pkg::ADDR_W
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_SRC-1:0] srcReq,
   input wire logic [3:0] cpuLevel,
   input wire logic cpuAck,
   output logic cpuIrqReq,
   output logic [3:0] cpuNewLevel,
   output logic [6:0] cpuVectorCode,
   output logic irq
);
   typedef struct packed {
      logic [NUM_SRC-1:0][2:0] prio;
      logic pendValid;
      logic [3:0] level;
      logic [6:0] vec;
      logic [intc_prio_pkg::NUM_EVT-1:0] evt;
      logic [intc_prio_pkg::NUM_EVT-1:0] mask;
   } state_s;

   state_s st_q;
   state_s st_d;
   state_s st_reset;

   logic wrFire;
   logic [ADDR_W-1:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrHit;
   logic [ADDR_W-1:0] rdAddr;
   logic [31:0] rdData;
   logic rdHit;
   logic found;
   logic [2:0] winPrio;
   logic [6:0] winVec;
   logic [intc_prio_pkg::NUM_EVT-1:0] evtSet;
   logic [intc_prio_pkg::NUM_EVT-1:0] evtClr;
   logic [intc_prio_pkg::REG_W-1:0] prioRegView [intc_prio_pkg::NUM_PRIO_REGS];
   logic [intc_prio_pkg::REG_W-1:0] statusView;

   axil_reg_slave #(
      .ADDR_W(ADDR_W)
   ) u_bus (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wrFire(wrFire),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrHit(wrHit),
      .rdAddr(rdAddr),
      .rdData(rdData),
      .rdHit(rdHit)
   );

   prio_arbiter #(
      .NUM_SRC(NUM_SRC)
   ) u_arb (
      .srcReq(srcReq),
      .srcPrio(st_q.prio),
      .cpuLevel(cpuLevel),
      .found(found),
      .winPrio(winPrio),
      .winVec(winVec)
   );

   always_comb begin
      st_reset = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         st_reset.prio[i] = intc_prio_pkg::PRIO_RESET;
      end
      st_reset.mask = intc_prio_pkg::EVT_MASK_RESET;
   end

   // only mapped fields are placed, all else reads zero
   // field placement comes from the source table
   always_comb begin
      for (int r = 0; r < intc_prio_pkg::NUM_PRIO_REGS; r++) begin
         prioRegView[r] = '0;
         for (int i = 0; i < NUM_SRC; i++) begin
            if (intc_prio_pkg::SRC_REG[i] == r) begin
               prioRegView[r][intc_prio_pkg::SRC_LSB[i] +: 3] = st_q.prio[i];
            end
         end
      end
   end

   always_comb begin
      statusView = '0;
      statusView[intc_prio_pkg::STAT_LEVEL_LSB +: 4] = st_q.level;
      statusView[intc_prio_pkg::STAT_VEC_LSB +: 7] = st_q.vec;
   end

   // register read mux; the status register is read only
   always_comb begin
      rdData = 32'h0;
      rdHit = 1'b0;
      for (int r = 0; r < intc_prio_pkg::NUM_PRIO_REGS; r++) begin
         if (rdAddr == intc_prio_pkg::PRIO_REG_OFF[r]) begin
            rdData = {16'h0, prioRegView[r]};
            rdHit = 1'b1;
         end
      end
      if (rdAddr == intc_prio_pkg::OFF_PENDING_VECTOR_STATUS) begin
         rdData = {16'h0, statusView};
         rdHit = 1'b1;
      end
      if (rdAddr == intc_prio_pkg::OFF_EVENT_STATUS) begin
         rdData = {30'h0, st_q.evt};
         rdHit = 1'b1;
      end
      if (rdAddr == intc_prio_pkg::OFF_EVENT_MASK) begin
         rdData = {30'h0, st_q.mask};
         rdHit = 1'b1;
      end
   end

   // write decode; a write to the status register is taken and has no effect
   always_comb begin
      wrHit = 1'b0;
      for (int r = 0; r < intc_prio_pkg::NUM_PRIO_REGS; r++) begin
         if (wrAddr == intc_prio_pkg::PRIO_REG_OFF[r]) begin
            wrHit = 1'b1;
         end
      end
      if (wrAddr == intc_prio_pkg::OFF_PENDING_VECTOR_STATUS ||
          wrAddr == intc_prio_pkg::OFF_EVENT_STATUS ||
          wrAddr == intc_prio_pkg::OFF_EVENT_MASK) begin
         wrHit = 1'b1;
      end
   end

   // a new winner, or a change of vector or level, counts as a new pending event
   always_comb begin
      evtSet = '0;
      evtSet[intc_prio_pkg::EVT_NEW_PENDING] = found &&
         (!st_q.pendValid || winVec != st_q.vec || {1'b0, winPrio} != st_q.level);
      evtSet[intc_prio_pkg::EVT_CPU_ACK] = cpuAck && st_q.pendValid;
      evtClr = '0;
      if (wrFire && wrAddr == intc_prio_pkg::OFF_EVENT_STATUS && wrStrb[0]) begin
         evtClr = wrData[intc_prio_pkg::NUM_EVT-1:0];
      end
   end

   always_comb begin
      st_d = st_q;
      // writes outside the fields are dropped
      for (int i = 0; i < NUM_SRC; i++) begin
         if (wrFire && wrAddr == intc_prio_pkg::PRIO_REG_OFF[intc_prio_pkg::SRC_REG[i]] &&
             wrStrb[intc_prio_pkg::SRC_LSB[i] / 8]) begin
            st_d.prio[i] = wrData[intc_prio_pkg::SRC_LSB[i] +: 3];
         end
      end
      if (wrFire && wrAddr == intc_prio_pkg::OFF_EVENT_MASK && wrStrb[0]) begin
         st_d.mask = wrData[intc_prio_pkg::NUM_EVT-1:0];
      end
      // set wins over a write-one clear in the same cycle
      st_d.evt = (st_q.evt & ~evtClr) | evtSet;
      // nothing pending reads as level 0, code 0
      st_d.pendValid = found;
      st_d.level = found ? {1'b0, winPrio} : 4'h0;
      st_d.vec = found ? winVec : 7'h00;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q <= st_reset;
      end else begin
         st_q <= st_d;
      end
   end

   // status fields are registered, so the cpu sees a one-cycle lag behind requests
   assign cpuIrqReq = st_q.pendValid;
   assign cpuNewLevel = st_q.level;
   assign cpuVectorCode = st_q.vec;
   assign irq = |(st_q.evt & st_q.mask);
endmodule

// ===== tb/intc_prio_assertions.sv
`timescale 1ns/10ps
module intc_prio_checker #(
   parameter int NUM_SRC = 14
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_SRC-1:0] srcReq,
   input wire logic [3:0] cpuLevel,
   input wire logic cpuAck,
   input wire logic cpuIrqReq,
   input wire logic [3:0] cpuNewLevel,
   input wire logic [6:0] cpuVectorCode,
   input wire logic irq
);
   logic [NUM_SRC-1:0] reqQ;
   logic vecOk;
   // winner must be a source that was requesting
   always_ff @(posedge ref_clk) begin
      reqQ <= srcReq;
   end
   always_comb begin
      vecOk = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (reqQ[i] && intc_prio_pkg::SRC_VEC[i] == cpuVectorCode) begin
            vecOk = 1'b1;
         end
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   level_above_cpu_a: assert property (cpuIrqReq |-> cpuNewLevel > $past(cpuLevel))
      else $error("pending level not above cpu level");
   level_user_range_a: assert property (cpuIrqReq |-> cpuNewLevel inside {[1:7]})
      else $error("pending level outside 1 to 7");
   no_request_idle_a: assert property (srcReq == '0 |=> !cpuIrqReq)
      else $error("pending with no source requesting");
   vector_from_source_a: assert property (cpuIrqReq |-> vecOk)
      else $error("vector code of a source not requesting");
   upper_half_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   unmapped_reads_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("unmapped read data not zero");
   read_answer_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed early");
   write_answer_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid)
      else $error("write response not two cycles after acceptance");
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property (cpuAck && cpuIrqReq);
   cover property (irq);
endmodule

// ===== tb/cpu_core_model.sv
`timescale 1ns/10ps
module cpu_core_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cpuIrqReq,
   input wire logic [3:0] cpuNewLevel,
   input wire logic [6:0] cpuVectorCode,
   input wire logic [3:0] baseLevel,
   input wire logic takeOn,
   input wire logic [3:0] ackWait,
   output logic [3:0] cpuLevel,
   output logic cpuAck,
   output logic [6:0] takenVec
);
   logic [3:0] waitCnt;
   // taking a vector raises the cpu level, as a real core does
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cpuLevel <= 4'h0;
         cpuAck <= 1'b0;
         takenVec <= 7'h0;
         waitCnt <= 4'h0;
      end else begin
         cpuAck <= 1'b0;
         if (!takeOn) begin
            cpuLevel <= baseLevel;
            waitCnt <= 4'h0;
         end else if (cpuIrqReq && !cpuAck) begin
            if (waitCnt == ackWait) begin
               cpuAck <= 1'b1;
               cpuLevel <= cpuNewLevel;
               takenVec <= cpuVectorCode;
               waitCnt <= 4'h0;
            end else begin
               waitCnt <= waitCnt + 4'h1;
            end
         end
      end
   end
endmodule

// ===== tb/interrupt_priority_and_status_test.sv
`timescale 1ns/10ps
bind interrupt_priority_and_status intc_prio_checker #(.NUM_SRC(NUM_SRC)) u_intc_prio_checker (.*);
module interrupt_priority_and_status_test;
   logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cpuAck, cpuIrqReq, irq, takeOn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, cpuLevel, cpuNewLevel, baseLevel, ackWait;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [13:0] srcReq;
   logic [6:0] cpuVectorCode, takenVec;
   int nMismatch = 0;
   int checksDone = 0;
   localparam logic [15:0] RST_V [6] = '{16'h4444, 16'h0044, 16'h4044, 16'h4404, 16'h0040, 16'h0040};
   localparam logic [15:0] MASK_V [6] = '{16'h7777, 16'h0077, 16'h7077, 16'h7707, 16'h0070, 16'h0070};
   // register index times 16 plus field low bit, per source index
   localparam int FLD [14] = '{0, 4, 8, 12, 16, 20, 32, 36, 44, 48, 56, 60, 68, 84};
   interrupt_priority_and_status u_interrupt_priority_and_status (.*);
   cpu_core_model u_cpu_core_model (.*);
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic closeOut;
      $display("mismatches %0d checks %0d", nMismatch, checksDone);
      if (nMismatch == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nMismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tmo(input int k);
      if (k >= 50) begin
         nMismatch++;
         closeOut();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      int k;
      logic aDone, dDone;
      @(posedge ref_clk);
      aDone = 1'b0;
      dDone = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50 && !(aDone && dDone); k++) begin
         @(posedge ref_clk);
         if (!aDone && s_axi_awready === 1'b1) begin
            aDone = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!dDone && s_axi_wready === 1'b1) begin
            dDone = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      tmo(k);
      for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++) @(posedge ref_clk);
      tmo(k);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int k;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      // arvalid stands until an edge samples arready high
      for (k = 0; k < 50; k++) begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) break;
      end
      tmo(k);
      s_axi_arvalid <= 1'b0;
      for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++) @(posedge ref_clk);
      tmo(k);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic tReset;
      for (int i = 0; i < 6; i++) rd(intc_prio_pkg::PRIO_REG_OFF[i], RST_V[i], 2'h0);
      rd(intc_prio_pkg::OFF_PENDING_VECTOR_STATUS, 32'h0, 2'h0);
   endtask
   task automatic tFields;
      for (int i = 0; i < 6; i++) begin
         wr(intc_prio_pkg::PRIO_REG_OFF[i], 16'hffff, 2'h0);
         rd(intc_prio_pkg::PRIO_REG_OFF[i], MASK_V[i], 2'h0);
         wr(intc_prio_pkg::PRIO_REG_OFF[i], 16'h0000, 2'h0);
      end
      wr(intc_prio_pkg::OFF_PENDING_VECTOR_STATUS, 16'hffff, 2'h0);
      rd(intc_prio_pkg::OFF_PENDING_VECTOR_STATUS, 32'h0, 2'h0);
      wr(8'h40, 16'hffff, 2'h2);
      rd(8'h40, 32'h0, 2'h2);
   endtask
   // all sources request, only one enabled: the rest must stay hidden
   task automatic tEach;
      srcReq <= 14'h3fff;
      for (int i = 0; i < 14; i++) begin
         wr(8'(FLD[i] / 16 * 4), 16'h0005 << (FLD[i] % 16), 2'h0);
         cyc(3);
         chk(cpuIrqReq, 1'b1);
         chk(cpuVectorCode, intc_prio_pkg::SRC_VEC[i]);
         rd(intc_prio_pkg::OFF_PENDING_VECTOR_STATUS, {20'h5, 1'b0, intc_prio_pkg::SRC_VEC[i]}, 2'h0);
         wr(8'(FLD[i] / 16 * 4), 16'h0000, 2'h0);
      end
      cyc(3);
      chk(cpuIrqReq, 1'b0);
   endtask
   task automatic tArb;
      wr(8'h00, 16'h6620, 2'h0);
      srcReq <= 14'h000f;
      cyc(3);
      chk(cpuVectorCode, intc_prio_pkg::SRC_VEC[2]);
      chk(cpuNewLevel, 4'h6);
      baseLevel <= 4'h6;
      cyc(3);
      chk(cpuIrqReq, 1'b0);
      wr(8'h00, 16'h7020, 2'h0);
      cyc(3);
      chk(cpuVectorCode, intc_prio_pkg::SRC_VEC[3]);
      chk(cpuNewLevel, 4'h7);
      baseLevel <= 4'h1;
      srcReq <= 14'h0003;
      cyc(3);
      chk(cpuVectorCode, intc_prio_pkg::SRC_VEC[1]);
      chk(cpuNewLevel, 4'h2);
   endtask
   task automatic tLanes;
      int k;
      s_axi_wstrb <= 4'h1;
      wr(8'h00, 16'h1111, 2'h0);
      s_axi_wstrb <= 4'hf;
      @(posedge ref_clk);
      s_axi_araddr <= 8'h00;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) break;
      end
      tmo(k);
      s_axi_arvalid <= 1'b0;
      // answer must stand while rready is low
      cyc(2);
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge ref_clk);
         if (s_axi_rvalid === 1'b1) break;
      end
      tmo(k);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, 32'h7011);
      chk(cpuIrqReq, 1'b0);
   endtask
   task automatic tEvents;
      int k;
      wr(intc_prio_pkg::OFF_EVENT_STATUS, 16'h0003, 2'h0);
      wr(intc_prio_pkg::OFF_EVENT_MASK, 16'h0003, 2'h0);
      chk(irq, 1'b0);
      srcReq <= 14'h0008;
      baseLevel <= 4'h0;
      cyc(3);
      chk(irq, 1'b1);
      wr(intc_prio_pkg::OFF_EVENT_MASK, 16'h0002, 2'h0);
      wr(intc_prio_pkg::OFF_EVENT_STATUS, 16'h0002, 2'h0);
      cyc(2);
      chk(irq, 1'b0);
      takeOn <= 1'b1;
      for (k = 0; k < 50 && cpuAck !== 1'b1; k++) @(posedge ref_clk);
      tmo(k);
      cyc(3);
      chk(takenVec, intc_prio_pkg::SRC_VEC[3]);
      chk(irq, 1'b1);
      chk(cpuIrqReq, 1'b0);
      wr(intc_prio_pkg::OFF_EVENT_STATUS, 16'h0003, 2'h0);
      cyc(2);
      chk(irq, 1'b0);
      takeOn <= 1'b0;
   endtask
   task automatic tReReset;
      srcReq <= 14'h0;
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      tReset();
      chk(irq, 1'b0);
   endtask
   initial begin
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, takeOn} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      srcReq = 14'h0;
      baseLevel = 4'h0;
      ackWait = 4'h4;
      cyc(16);
      rst_n <= 1'b1;
      tReset();
      tFields();
      tEach();
      tArb();
      tLanes();
      tEvents();
      tReReset();
      closeOut();
   end
endmodule
